// ===== link_protect_map.vh
`ifndef LINK_PROTECT_MAP_VH
`define LINK_PROTECT_MAP_VH

// ************************************************
// register offsets
// ************************************************
`define OFS_OWN_KEY_VECTOR_BYTE0 8'h90
`define OFS_OWN_KEY_VECTOR_BYTE1 8'h91
`define OFS_OWN_KEY_VECTOR_BYTE2 8'h92
`define OFS_OWN_KEY_VECTOR_BYTE3 8'h93
`define OFS_OWN_KEY_VECTOR_BYTE4 8'h94
`define OFS_RECEIVER_CAPABILITIES 8'ha0
`define OFS_RECEIVER_TOPOLOGY_LOW 8'ha1
`define OFS_RECEIVER_TOPOLOGY_HIGH 8'ha2
`define OFS_DOWNSTREAM_KEY_LIST_PORT 8'ha3
`define OFS_PROTECTION_DEBUG_CONTROL 8'hc0

// ************************************************
// field positions
// ************************************************
`define CAP_REPEATER 6
`define CAP_KEY_LIST_READY 5
`define CAP_FAST_BUS 4
`define CAP_FEATURES 1
`define CAP_QUICK_REAUTH 0
`define TOPO_DEVICE_LIMIT_ERROR 7
`define TOPO_CASCADE_LIMIT_ERROR 3
`define DBG_PROTECT_BUS_TIMEOUT_DISABLE 6
`define DBG_LINK_CHECK_SYNC_DISABLE 4
`define DBG_LINE_CHECKSUM_ENABLE 3
`define DBG_FRAME_COUNTER_TEST 2
`define DBG_AUTH_TIMER_ACCELERATE 1
`define DBG_PROTECT_BUS_FAST_TIMING 0
`define DBG_WRITE_MASK 8'h5f

// ************************************************
// reset values
// ************************************************
`define RST_BYTE 8'h00
`define RST_DEBUG_CONTROL 8'h00

// ************************************************
// frame counter periods, as masks of the low count bits
// ************************************************
`define PJ_MASK_NORMAL 7'h0f
`define PJ_MASK_TEST 7'h01
`define RI_MASK_NORMAL 7'h7f
`define RI_MASK_TEST 7'h0f

// ************************************************
// timing
// ************************************************
`define CLK_KHZ 50000
`define BUS_TIMEOUT_MS 1000
`define BUS_TIMEOUT_CYCLES (`BUS_TIMEOUT_MS * `CLK_KHZ)
`define AUTH_TICK_US 1000
`define AUTH_TICK_CYCLES (`AUTH_TICK_US * `CLK_KHZ / 1000)
`define AUTH_TICK_FAST_CYCLES 50

`endif

// ===== line_checksum.v
`include "link_protect_map.vh"

module line_checksum #(
   parameter W = 8
) (
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire enable,
   input wire pix_valid,
   input wire [W-1:0] pix,
   input wire line_end,
   output reg [W-1:0] sum_q,
   output reg sum_valid_q
);

   reg [W-1:0] acc_q;
   reg [W:0] raw;
   reg [W-1:0] acc_next;

   // ************************************************
   // ones-complement accumulate with end-around carry
   // ************************************************
   always @* begin
      raw = {1'b0, acc_q} + {1'b0, (pix_valid ? pix : {W{1'b0}})};
      acc_next = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
   end

   always @(posedge mclk) begin
      if (rst) begin
         acc_q <= {W{1'b0}};
         sum_q <= {W{1'b0}};
         sum_valid_q <= 1'b0;
      end else if (ce) begin
         sum_valid_q <= 1'b0;
         if (line_end) begin
            acc_q <= {W{1'b0}};
            if (enable) begin
               sum_q <= ~acc_next;
               sum_valid_q <= 1'b1;
            end
         end else begin
            acc_q <= acc_next;
         end
      end
   end

endmodule // line_checksum

// ===== idle_timeout.v
`include "link_protect_map.vh"

module idle_timeout #(
   parameter CW = 32,
   parameter [CW-1:0] LIMIT = `BUS_TIMEOUT_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire disable_timeout,
   input wire activity,
   output reg expired_q
);

   reg [CW-1:0] cnt_q;

   // ************************************************
   // silence counter, free once limit is passed
   // ************************************************
   always @(posedge mclk) begin
      if (rst) begin
         cnt_q <= {CW{1'b0}};
         expired_q <= 1'b0;
      end else if (ce) begin
         if (disable_timeout || activity) begin
            cnt_q <= {CW{1'b0}};
            expired_q <= 1'b0;
         end else if (cnt_q > LIMIT) begin
            expired_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // idle_timeout

// ===== link_protect_status_regs.v
// Summary of operation
// RQ1: own five-byte key vector readable at 0x90..0x94, low byte first, reset zero.
// RQ2: capability bit 6 shows receiver repeater; valid after receiver key ready.
// RQ3: capability bit 5 set when receiver key list and V' are done.
// RQ4: capability bit 4 mirrors receiver fast bus, unused by this device.
// RQ5: capability bit 1 shows receiver enhanced signalling, cipher and verification.
// RQ6: capability bit 0 shows receiver accepts clear video during reauthentication.
// RQ7: topology low bit 7 flags device count beyond key list depth.
// RQ8: seven-bit device count behind repeater; zero for plain receiver.
// RQ9: topology high bit 3 flags more than seven cascade levels.
// RQ10: three-bit cascade depth below the repeater.
// RQ11: each key list port read returns next list byte and advances.
// RQ12: protection bus free after over one second idle; debug bit 6 disables.
// RQ13: link check before and after frame 128; bit 4 drops frame 127 check.
// RQ14: debug bit 3 sends per-channel ones-complement checksum after each line.
// RQ15: test bit: Pj every 2, Ri every 16; else every 16 and 128.
// RQ16: debug bit 1 speeds authentication timers for test.
// RQ17: debug bit 0 selects fast bus timing; mirrored to indirect status.
// RQ18: reserved bits read zero; writes to them ignored.
// RQ19: key list read position returns to first byte on new authentication.
`include "link_protect_map.vh"

module link_protect_status_regs #(
   parameter MAX_DEVS = 16,
   parameter LIST_AW = 7,
   parameter [31:0] BUS_TIMEOUT_CYCLES = `BUS_TIMEOUT_CYCLES,
   parameter [31:0] AUTH_TICK_CYCLES = `AUTH_TICK_CYCLES,
   parameter [31:0] AUTH_TICK_FAST_CYCLES = `AUTH_TICK_FAST_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   output reg reg_rvalid_q,
   input wire [39:0] own_key_vector,
   input wire rx_repeater,
   input wire rx_key_list_ready,
   input wire rx_fast_bus,
   input wire rx_features,
   input wire rx_quick_reauth,
   input wire rx_device_limit_error,
   input wire [6:0] rx_device_count,
   input wire rx_cascade_limit_error,
   input wire [2:0] rx_cascade_depth,
   input wire auth_start,
   input wire list_wr,
   input wire [7:0] list_wdata,
   input wire bus_activity,
   input wire frame_start,
   input wire pix_valid,
   input wire [23:0] pix_rgb,
   input wire line_end,
   output reg protect_bus_free_q,
   output reg protect_bus_fast_timing_q,
   output reg indirect_status_mirror_q,
   output reg auth_timer_accelerate_q,
   output reg auth_tick_q,
   output reg pj_check_q,
   output reg ri_check_q,
   output reg ri_sync_check_q,
   output reg [23:0] line_checksum_q,
   output reg line_checksum_valid_q
);

   localparam LIST_DEPTH = 1 << LIST_AW;

   reg [7:0] debug_q;
   reg [39:0] own_key_q;
   reg [7:0] caps_q;
   reg [7:0] topo_low_q;
   reg [7:0] topo_high_q;
   reg [7:0] list_mem [0:LIST_DEPTH-1];
   reg [LIST_AW:0] list_wptr_q;
   reg [LIST_AW:0] list_rptr_q;
   reg [6:0] frame_cnt_q;
   reg [31:0] tick_cnt_q;
   reg [7:0] rd_mux;
   wire [6:0] frame_next;
   wire [6:0] pj_mask;
   wire [6:0] ri_mask;
   wire [31:0] tick_limit;
   wire bus_expired;
   wire [23:0] chk_sum;
   wire [2:0] chk_valid;
   wire list_has_data;

   // ************************************************
   // status mirrors
   // ************************************************
   always @(posedge mclk) begin
      if (rst) begin
         own_key_q <= {5{`RST_BYTE}};
         caps_q <= `RST_BYTE;
         topo_low_q <= `RST_BYTE;
         topo_high_q <= `RST_BYTE;
      end else if (ce) begin
         // RQ1: own vector capture
         own_key_q <= own_key_vector;
         // RQ18: reserved bits zero
         caps_q <= `RST_BYTE;
         // RQ2: repeater flag
         caps_q[`CAP_REPEATER] <= rx_repeater;
         // RQ3: list ready flag
         caps_q[`CAP_KEY_LIST_READY] <= rx_key_list_ready;
         // RQ4: fast bus mirror
         caps_q[`CAP_FAST_BUS] <= rx_fast_bus;
         // RQ5: feature flag
         caps_q[`CAP_FEATURES] <= rx_features;
         // RQ6: quick reauth flag
         caps_q[`CAP_QUICK_REAUTH] <= rx_quick_reauth;
         // RQ8: device count
         topo_low_q[6:0] <= rx_device_count;
         // RQ7: device limit error
         topo_low_q[`TOPO_DEVICE_LIMIT_ERROR] <= rx_device_limit_error
            || (rx_device_count > MAX_DEVS[6:0]);
         topo_high_q <= `RST_BYTE;
         // RQ9: cascade limit error
         topo_high_q[`TOPO_CASCADE_LIMIT_ERROR] <= rx_cascade_limit_error;
         // RQ10: cascade depth
         topo_high_q[2:0] <= rx_cascade_depth;
      end
   end

   // ************************************************
   // debug control register
   // ************************************************
   always @(posedge mclk) begin
      if (rst) begin
         debug_q <= `RST_DEBUG_CONTROL;
      end else if (ce && reg_wr && reg_addr == `OFS_PROTECTION_DEBUG_CONTROL) begin
         // RQ18: masked write
         debug_q <= reg_wdata & `DBG_WRITE_MASK;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         protect_bus_fast_timing_q <= 1'b0;
         indirect_status_mirror_q <= 1'b0;
         auth_timer_accelerate_q <= 1'b0;
      end else if (ce) begin
         // RQ17: fast timing and mirror
         protect_bus_fast_timing_q <= debug_q[`DBG_PROTECT_BUS_FAST_TIMING];
         indirect_status_mirror_q <= debug_q[`DBG_PROTECT_BUS_FAST_TIMING];
         // RQ16: timer accelerate flag
         auth_timer_accelerate_q <= debug_q[`DBG_AUTH_TIMER_ACCELERATE];
      end
   end

   // ************************************************
   // downstream key list buffer
   // ************************************************
   assign list_has_data = (list_rptr_q != list_wptr_q);

   always @(posedge mclk) begin
      if (ce && list_wr && !list_wptr_q[LIST_AW]) begin
         list_mem[list_wptr_q[LIST_AW-1:0]] <= list_wdata;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         list_wptr_q <= {(LIST_AW+1){1'b0}};
         list_rptr_q <= {(LIST_AW+1){1'b0}};
      end else if (ce) begin
         if (auth_start) begin
            // RQ19: restart list
            list_wptr_q <= {(LIST_AW+1){1'b0}};
            list_rptr_q <= {(LIST_AW+1){1'b0}};
         end else begin
            if (list_wr && !list_wptr_q[LIST_AW]) begin
               list_wptr_q <= list_wptr_q + {{LIST_AW{1'b0}}, 1'b1};
            end
            // RQ11: advance on read
            if (reg_rd && reg_addr == `OFS_DOWNSTREAM_KEY_LIST_PORT && list_has_data) begin
               list_rptr_q <= list_rptr_q + {{LIST_AW{1'b0}}, 1'b1};
            end
         end
      end
   end

   // ************************************************
   // register read
   // ************************************************
   always @* begin
      case (reg_addr)
         // RQ1: low byte first
         `OFS_OWN_KEY_VECTOR_BYTE0: rd_mux = own_key_q[7:0];
         `OFS_OWN_KEY_VECTOR_BYTE1: rd_mux = own_key_q[15:8];
         `OFS_OWN_KEY_VECTOR_BYTE2: rd_mux = own_key_q[23:16];
         `OFS_OWN_KEY_VECTOR_BYTE3: rd_mux = own_key_q[31:24];
         `OFS_OWN_KEY_VECTOR_BYTE4: rd_mux = own_key_q[39:32];
         `OFS_RECEIVER_CAPABILITIES: rd_mux = caps_q;
         `OFS_RECEIVER_TOPOLOGY_LOW: rd_mux = topo_low_q;
         `OFS_RECEIVER_TOPOLOGY_HIGH: rd_mux = topo_high_q;
         // RQ11: next list byte
         `OFS_DOWNSTREAM_KEY_LIST_PORT: rd_mux = list_has_data ?
            list_mem[list_rptr_q[LIST_AW-1:0]] : `RST_BYTE;
         `OFS_PROTECTION_DEBUG_CONTROL: rd_mux = debug_q;
         default: rd_mux = `RST_BYTE;
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         reg_rdata_q <= `RST_BYTE;
         reg_rvalid_q <= 1'b0;
      end else if (ce) begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            reg_rdata_q <= rd_mux;
         end
      end
   end

   // ************************************************
   // protection bus timeout
   // ************************************************
   // RQ12: one second idle
   idle_timeout #(
      .CW(32),
      .LIMIT(BUS_TIMEOUT_CYCLES)
   ) u_bus_timeout (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .disable_timeout(debug_q[`DBG_PROTECT_BUS_TIMEOUT_DISABLE]),
      .activity(bus_activity),
      .expired_q(bus_expired)
   );

   always @(posedge mclk) begin
      if (rst) begin
         protect_bus_free_q <= 1'b0;
      end else if (ce) begin
         protect_bus_free_q <= bus_expired;
      end
   end

   // ************************************************
   // frame counter and link checks
   // ************************************************
   // RQ15: period select
   assign pj_mask = debug_q[`DBG_FRAME_COUNTER_TEST] ? `PJ_MASK_TEST : `PJ_MASK_NORMAL;
   assign ri_mask = debug_q[`DBG_FRAME_COUNTER_TEST] ? `RI_MASK_TEST : `RI_MASK_NORMAL;
   assign frame_next = frame_cnt_q + 7'h01;

   always @(posedge mclk) begin
      if (rst) begin
         frame_cnt_q <= 7'h00;
         pj_check_q <= 1'b0;
         ri_check_q <= 1'b0;
         ri_sync_check_q <= 1'b0;
      end else if (ce) begin
         pj_check_q <= 1'b0;
         ri_check_q <= 1'b0;
         ri_sync_check_q <= 1'b0;
         if (auth_start) begin
            frame_cnt_q <= 7'h00;
         end else if (frame_start) begin
            frame_cnt_q <= frame_next;
            // RQ15: periodic checks
            pj_check_q <= ((frame_next & pj_mask) == 7'h00);
            ri_check_q <= ((frame_next & ri_mask) == 7'h00);
            // RQ13: frame before period
            ri_sync_check_q <= ((frame_next & ri_mask) == ri_mask)
               && !debug_q[`DBG_LINK_CHECK_SYNC_DISABLE];
         end
      end
   end

   // ************************************************
   // authentication timer tick
   // ************************************************
   // RQ16: faster prescale
   assign tick_limit = debug_q[`DBG_AUTH_TIMER_ACCELERATE] ?
      AUTH_TICK_FAST_CYCLES : AUTH_TICK_CYCLES;

   always @(posedge mclk) begin
      if (rst) begin
         tick_cnt_q <= 32'h00000000;
         auth_tick_q <= 1'b0;
      end else if (ce) begin
         auth_tick_q <= 1'b0;
         if (tick_cnt_q + 32'h00000001 >= tick_limit) begin
            tick_cnt_q <= 32'h00000000;
            auth_tick_q <= 1'b1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
         end
      end
   end

   // ************************************************
   // per-line video checksums
   // ************************************************
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_chk
         // RQ14: per channel checksum
         line_checksum #(
            .W(8)
         ) u_chk (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .enable(debug_q[`DBG_LINE_CHECKSUM_ENABLE]),
            .pix_valid(pix_valid),
            .pix(pix_rgb[ch*8 +: 8]),
            .line_end(line_end),
            .sum_q(chk_sum[ch*8 +: 8]),
            .sum_valid_q(chk_valid[ch])
         );
      end
   endgenerate

   always @(posedge mclk) begin
      if (rst) begin
         line_checksum_q <= 24'h000000;
         line_checksum_valid_q <= 1'b0;
      end else if (ce) begin
         line_checksum_valid_q <= chk_valid[0];
         if (chk_valid[0]) begin
            line_checksum_q <= chk_sum;
         end
      end
   end

endmodule // link_protect_status_regs

// ===== link_protect_status_regs_props.sv
module link_protect_status_regs_props (
   input wire mclk,
   input wire rst,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   input wire [7:0] reg_rdata_q,
   input wire reg_rvalid_q,
   input wire [39:0] own_key_vector,
   input wire [6:0] rx_device_count,
   input wire bus_activity,
   input wire line_end,
   input wire frame_start,
   input wire protect_bus_free_q,
   input wire protect_bus_fast_timing_q,
   input wire indirect_status_mirror_q,
   input wire auth_timer_accelerate_q,
   input wire pj_check_q,
   input wire ri_check_q,
   input wire ri_sync_check_q,
   input wire line_checksum_valid_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************
   // port relations
   // ************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rd_answer;
      ce && reg_rd |=> reg_rvalid_q;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_own_key;
      ce && reg_rd && reg_addr == 8'h90 && !$past(rst) && $stable(own_key_vector)
         |=> reg_rdata_q == $past(own_key_vector[7:0]);
   endproperty
   a_own_key: assert property (p_own_key) else $error("key byte0 wrong");
   property p_dev_count;
      ce && reg_rd && reg_addr == 8'ha1 && !$past(rst) && $stable(rx_device_count)
         |=> reg_rdata_q[6:0] == $past(rx_device_count);
   endproperty
   a_dev_count: assert property (p_dev_count) else $error("device count wrong");
   property p_rsv_zero;
      ce && reg_rd && reg_addr == 8'hc0 |=> reg_rdata_q[7] == 1'b0 && reg_rdata_q[5] == 1'b0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
   property p_fast;
      ce && reg_wr && reg_addr == 8'hc0 ##1 !reg_wr |=>
         {protect_bus_fast_timing_q, indirect_status_mirror_q} == {2{$past(reg_wdata[0], 2)}};
   endproperty
   a_fast: assert property (p_fast) else $error("fast timing wrong");
   property p_accel;
      ce && reg_wr && reg_addr == 8'hc0 ##1 !reg_wr |=>
         auth_timer_accelerate_q == $past(reg_wdata[1], 2);
   endproperty
   a_accel: assert property (p_accel) else $error("timer speedup wrong");
   property p_busy_act;
      ce && bus_activity |-> ##3 !protect_bus_free_q;
   endproperty
   a_busy_act: assert property (p_busy_act) else $error("free despite activity");
   property p_busy_dis;
      ce && reg_wr && reg_addr == 8'hc0 && reg_wdata[6] |-> ##4 !protect_bus_free_q;
   endproperty
   a_busy_dis: assert property (p_busy_dis) else $error("free while disabled");
   property p_pj_frame;
      pj_check_q |-> $past(frame_start);
   endproperty
   a_pj_frame: assert property (p_pj_frame) else $error("pj check off frame");
   property p_ri_in_pj;
      ri_check_q |-> pj_check_q;
   endproperty
   a_ri_in_pj: assert property (p_ri_in_pj) else $error("ri check off period");
   property p_sync;
      ri_sync_check_q |-> !ri_check_q && $past(frame_start);
   endproperty
   a_sync: assert property (p_sync) else $error("sync check misplaced");
   property p_sum;
      line_checksum_valid_q |-> $past(line_end, 2);
   endproperty
   a_sum: assert property (p_sum) else $error("checksum off line end");
   c_free: cover property (protect_bus_free_q);
   c_sync: cover property (ri_sync_check_q);
   c_sum: cover property (line_checksum_valid_q);
endmodule // link_protect_status_regs_props

bind link_protect_status_regs link_protect_status_regs_props i_props (.*);

// ===== rx_model.sv
module rx_model (
   input wire mclk,
   input wire rst,
   input wire auth_start,
   input wire slow,
   input wire [6:0] rx_device_count,
   input wire [2:0] rx_cascade_depth,
   output reg rx_key_list_ready,
   output reg list_wr,
   output reg [7:0] list_wdata,
   output wire rx_repeater,
   output wire rx_fast_bus,
   output wire rx_features,
   output wire rx_quick_reauth
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************
   // downstream receiver
   // ************************************************
   reg [9:0] left_q;
   assign rx_repeater = rx_device_count != 7'h00;
   assign rx_fast_bus = rx_cascade_depth[1];
   assign rx_features = 1'b1;
   assign rx_quick_reauth = rx_cascade_depth[0];
   always @(posedge mclk) begin
      if (rst || auth_start) begin
         left_q <= rst ? 10'h000 : {1'b0, rx_device_count, 2'b00} + {3'h0, rx_device_count};
         rx_key_list_ready <= 1'b0;
         list_wr <= 1'b0;
         list_wdata <= 8'h00;
      end else if (left_q != 10'h000 && !(slow && list_wr)) begin
         list_wr <= 1'b1;
         list_wdata <= left_q[7:0] ^ 8'h5a;
         left_q <= left_q - 10'h001;
      end else begin
         list_wr <= 1'b0;
         list_wdata <= ~list_wdata;
         rx_key_list_ready <= left_q == 10'h000;
      end
   end
endmodule // rx_model

// ===== test_link_protect_status_regs.sv
module test_link_protect_status_regs;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [39:0] own_key_vector = 40'h9a7c35e108;
   logic rx_device_limit_error = 1'b0, rx_cascade_limit_error = 1'b0, auth_start = 1'b0;
   logic [6:0] rx_device_count = 7'h00;
   logic [2:0] rx_cascade_depth = 3'h0;
   logic bus_activity = 1'b0, frame_start = 1'b0, pix_valid = 1'b0, line_end = 1'b0;
   logic [23:0] pix_rgb = 24'h000000;
   wire [7:0] reg_rdata_q, list_wdata;
   wire [23:0] line_checksum_q;
   wire reg_rvalid_q, rx_repeater, rx_key_list_ready, rx_fast_bus, rx_features;
   wire rx_quick_reauth, list_wr, protect_bus_free_q, protect_bus_fast_timing_q;
   wire indirect_status_mirror_q, auth_timer_accelerate_q, auth_tick_q, pj_check_q;
   wire ri_check_q, ri_sync_check_q, line_checksum_valid_q;
   int fails = 0, n_checks = 0, n_pj = 0, n_ri = 0, n_sync = 0, n_sum = 0;

   link_protect_status_regs #(.BUS_TIMEOUT_CYCLES(32'h32), .AUTH_TICK_CYCLES(32'h14),
      .AUTH_TICK_FAST_CYCLES(32'h4)) i_dut (.*);
   rx_model i_rx (.*);

   // ************************************************
   // helpers
   // ************************************************
   always #10 mclk = ~mclk;
   always @(negedge mclk) begin
      n_pj += (pj_check_q === 1'b1);
      n_ri += (ri_check_q === 1'b1);
      n_sync += (ri_sync_check_q === 1'b1);
      n_sum += (line_checksum_valid_q === 1'b1);
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      check({23'h0, reg_rvalid_q}, 24'h1);
      check({16'h0, reg_rdata_q}, {16'h0, exp});
   endtask
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      repeat (2) begin
         do begin
            @(negedge mclk);
            n++;
         end while (auth_tick_q !== 1'b1 && n < 400);
      end
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (auth_tick_q !== 1'b1 && n < 200);
      check(n[23:0], exp[23:0]);
   endtask
   task automatic session(input logic [6:0] c, input logic [2:0] d, input logic e, input logic s);
      int n;
      rx_device_count = c;
      rx_cascade_depth = d;
      rx_cascade_limit_error = e;
      slow = s;
      rx_device_limit_error = e;
      n = 5 * c;
      repeat (2) begin
         @(negedge mclk);
         auth_start = 1'b1;
         @(negedge mclk);
         auth_start = 1'b0;
         tick(2);
      end
      for (int i = 0; i < 1000 && rx_key_list_ready !== 1'b1; i++) @(negedge mclk);
      rdc(8'ha0, {1'b0, c != 7'h00, 1'b1, d[1], 2'b00, 1'b1, d[0]});
      rdc(8'ha1, {c > 7'h10 || e, c});
      rdc(8'ha2, {4'h0, e, d});
      for (int k = 0; k < n; k++) rdc(8'ha3, 8'(n - k) ^ 8'h5a);
      rdc(8'ha3, 8'h00);
      $display("end of session test, %0d list bytes", n);
   endtask
   task automatic frame_run(input logic [7:0] d, input int n, input int pj, input int ri,
         input int sy);
      wr(8'hc0, d);
      n_pj = 0;
      n_ri = 0;
      n_sync = 0;
      repeat (n) begin
         @(negedge mclk);
         frame_start = 1'b1;
         @(negedge mclk);
         frame_start = 1'b0;
      end
      tick(3);
      check(n_pj[23:0], pj[23:0]);
      check(n_ri[23:0], ri[23:0]);
      check(n_sync[23:0], sy[23:0]);
      $display("end of frame test %h", d);
   endtask
   task automatic line(input logic [7:0] d);
      wr(8'hc0, d);
      @(negedge mclk);
      pix_valid = 1'b1;
      pix_rgb = 24'hf08001;
      @(negedge mclk);
      pix_rgb = 24'h2090ff;
      line_end = 1'b1;
      @(negedge mclk);
      pix_valid = 1'b0;
      line_end = 1'b0;
      tick(4);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ************************************************
   // tests
   // ************************************************
   initial begin
      #200us;
      fails++;
      report_and_stop;
   end
   initial begin
      tick(5);
      rst = 1'b0;
      tick(2);
      for (int i = 0; i < 5; i++) rdc(8'h90 + 8'(i), own_key_vector[8*i +: 8]);
      rdc(8'hc0, 8'h00);
      rdc(8'h95, 8'h00);
      $display("end of reset test");
      wr(8'hc0, 8'hff);
      rdc(8'hc0, 8'h5f);
      check({22'h0, protect_bus_fast_timing_q, indirect_status_mirror_q}, 24'h3);
      check({23'h0, auth_timer_accelerate_q}, 24'h1);
      tick_gap(4);
      wr(8'h90, 8'hff);
      rdc(8'h90, own_key_vector[7:0]);
      wr(8'hc0, 8'h00);
      tick(1);
      check({22'h0, protect_bus_fast_timing_q, indirect_status_mirror_q}, 24'h0);
      tick_gap(20);
      $display("end of debug test");
      session(7'h03, 3'h2, 1'b0, 1'b0);
      session(7'h11, 3'h7, 1'b1, 1'b1);
      session(7'h00, 3'h1, 1'b1, 1'b0);
      frame_run(8'h04, 32, 16, 2, 2);
      frame_run(8'h14, 32, 16, 2, 0);
      frame_run(8'h00, 64, 4, 1, 1);
      line(8'h08);
      check(line_checksum_q, 24'heeeefe);
      line(8'h00);
      check(n_sum[23:0], 24'h1);
      $display("end of checksum test");
      tick(60);
      check({23'h0, protect_bus_free_q}, 24'h1);
      @(negedge mclk);
      bus_activity = 1'b1;
      @(negedge mclk);
      bus_activity = 1'b0;
      tick(3);
      check({23'h0, protect_bus_free_q}, 24'h0);
      tick(60);
      wr(8'hc0, 8'h40);
      tick(3);
      check({23'h0, protect_bus_free_q}, 24'h0);
      tick(60);
      check({23'h0, protect_bus_free_q}, 24'h0);
      wr(8'hc0, 8'h00);
      tick(60);
      ce = 1'b0;
      bus_activity = 1'b1;
      tick(3);
      bus_activity = 1'b0;
      ce = 1'b1;
      tick(3);
      check({23'h0, protect_bus_free_q}, 24'h1);
      $display("end of timeout test");
      report_and_stop;
   end
endmodule // test_link_protect_status_regs
